/* File: dv/core_model.sv */
// Core-side model: instruction boundaries, program counter and its jumps
`timescale 1ns/1ps
module core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step,
    input wire logic step_return,
    input wire irq_ctrl_pkg::flag_pair_s step_flags,
    input wire logic [3:0] step_ldi_cycle,
    input wire logic step_ldi_clear,
    input wire logic take_irq,
    input wire logic [11:0] pc_load,
    input wire logic pop_valid,
    input wire logic [11:0] pc_pop,
    output irq_ctrl_pkg::core_req_s core_req
);
    import irq_ctrl_pkg::*;
    logic [11:0] pc_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_req <= '0;
            pc_reg <= 12'h100;
        end else begin
            core_req <= '{step, step & step_return, pc_reg, step_flags,
                step_ldi_cycle, step & step_ldi_clear};
            if (take_irq) pc_reg <= pc_load;
            else if (pop_valid) pc_reg <= pc_pop;
            else if (step) pc_reg <= pc_reg + 12'h001;
        end
    end
endmodule

/* File: dv/priority_interrupt_controller_bench.sv */
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module priority_interrupt_controller_bench;
    import irq_ctrl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0] sn = 5'h1f;  // Source lines, idle high
    logic [5:0] ev = '0;
    logic st = 1'b0, rt = 1'b0, ldc = 1'b0;
    logic [3:0] ldn = '0;
    flag_pair_s fl = '0;
    flag_pair_s flags_out;
    core_req_s core_req;
    cpu_mode_e mode_out;
    logic take_irq, pop_valid, wake;
    logic [11:0] pc_load, stack_push, pc_pop;
    logic [11:0] stk[$];
    int n_mismatch = 0, checked = 0;

    always #4 aclk = ~aclk;

    priority_interrupt_controller u_priority_interrupt_controller (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_n(sn[0]), .supply_supervisor(ev[0]),
        .src1_n(sn[1]), .spi_done(ev[1]), .src2_n(sn[2]), .port_event(ev[2]), .src3_n(sn[3]),
        .timer_ovf(ev[3]), .osc32k_event(ev[4]), .src4_n(sn[4]), .adc_done(ev[5]), .core_req,
        .take_irq, .pc_load, .stack_push, .pc_pop, .pop_valid, .flags_out, .mode_out, .wake
    );
    core_model u_core_model (
        .aclk, .aresetn, .step(st), .step_return(rt), .step_flags(fl), .step_ldi_cycle(ldn),
        .step_ldi_clear(ldc), .take_irq, .pc_load, .pop_valid, .pc_pop, .core_req
    );

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        cmp("bresp", er, s_axi_bresp);
        // One idle edge, so a following call never re-raises bready in this step
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        cmp("rresp", er, s_axi_rresp);
        cmp("rdata", ed, s_axi_rdata);
        @(posedge aclk);
    endtask

    // One instruction boundary, then the controller's answer one cycle on
    task automatic instr(input logic r, input logic et, input logic [11:0] v,
            input logic [1:0] em);
        logic [11:0] pcs;
        st <= 1'b1;
        rt <= r;
        @(posedge aclk);
        st <= 1'b0;
        @(posedge aclk);
        pcs = core_req.pc;
        #1;
        cmp("take_irq", et, take_irq);
        cmp("mode_out", em, mode_out);
        if (et) begin
            cmp("pc_load", v, pc_load);
            cmp("stack_push", pcs, stack_push);
            stk.push_back(pcs);
        end
        if (r) begin
            cmp("pop_valid", 1'b1, pop_valid);
            cmp("pc_pop", stk.pop_back(), pc_pop);
        end
        @(posedge aclk);
    endtask

    task automatic pulse_n(input int i);
        sn[i] <= 1'b0;
        repeat (2) @(posedge aclk);
        sn[i] <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    task automatic t_enable();
        axi_rd(12'h0cc, 32'h0000_0000, RESP_OKAY);
        axi_rd(12'h0c8, 32'h0000_0000, RESP_SLVERR);
        axi_wr(12'h0c8, 8'h8f, RESP_OKAY);
        axi_wr(12'h010, 8'h10, RESP_SLVERR);
        // Write without the low byte lane must leave the enable clear
        s_axi_wstrb <= 4'he;
        axi_wr(12'h0c8, 8'h10, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        sn[3] <= 1'b0;
        instr(1'b0, 1'b0, 12'h000, 2'h0);
        pulse_n(0);
        cmp("wake", 1'b0, wake);
        instr(1'b0, 1'b1, 12'hffc, 2'h2);
        axi_rd(12'h0cc, 32'h0000_0002, RESP_OKAY);
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        instr(1'b0, 1'b0, 12'h000, 2'h0);
        sn[3] <= 1'b1;
        $display("enable test done");
    endtask

    task automatic t_prio();
        axi_wr(12'h0c8, 8'h50, RESP_OKAY);
        fl <= 2'h3;
        instr(1'b0, 1'b0, 12'h000, 2'h0);
        sn[4:1] <= 4'h0;
        repeat (2) @(posedge aclk);
        cmp("wake", 1'b1, wake);
        instr(1'b0, 1'b1, 12'hff6, 2'h1);
        cmp("flags_out", 2'h0, flags_out);
        fl <= 2'h1;
        instr(1'b0, 1'b0, 12'h000, 2'h1);
        pulse_n(0);
        instr(1'b0, 1'b1, 12'hffc, 2'h2);
        cmp("flags_out", 2'h0, flags_out);
        instr(1'b1, 1'b0, 12'h000, 2'h1);
        cmp("flags_out", 2'h1, flags_out);
        sn[1] <= 1'b1;
        fl <= 2'h3;
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        cmp("flags_out", 2'h3, flags_out);
        instr(1'b0, 1'b1, 12'hff4, 2'h1);
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        instr(1'b0, 1'b1, 12'hff2, 2'h1);
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        sn[3] <= 1'b1;
        instr(1'b0, 1'b1, 12'hff0, 2'h1);
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        sn[4] <= 1'b1;
        instr(1'b0, 1'b0, 12'h000, 2'h0);
        $display("priority test done");
    endtask

    task automatic t_edge();
        axi_wr(12'h0c8, 8'h30, RESP_OKAY);
        sn[2] <= 1'b0;
        repeat (3) @(posedge aclk);
        instr(1'b0, 1'b0, 12'h000, 2'h0);
        sn[2] <= 1'b1;
        repeat (2) @(posedge aclk);
        pulse_n(1);
        instr(1'b0, 1'b1, 12'hff6, 2'h1);
        pulse_n(1);
        pulse_n(1);
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        instr(1'b0, 1'b1, 12'hff6, 2'h1);
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        instr(1'b0, 1'b1, 12'hff4, 2'h1);
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        instr(1'b0, 1'b0, 12'h000, 2'h0);
        $display("edge test done");
    endtask

    task automatic t_periph();
        logic [11:0] vt[6] = '{12'hffc, 12'hff6, 12'hff4, 12'hff2, 12'hff2, 12'hff0};
        axi_wr(12'h0c8, 8'h10, RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            ev[i] <= 1'b1;
            repeat (2) @(posedge aclk);
            if (i < 3) ev[i] <= 1'b0;  // Latched sources need only a pulse
            repeat (2) @(posedge aclk);
            instr(1'b0, 1'b1, vt[i], (i == 0) ? 2'h2 : 2'h1);
            ev[i] <= 1'b0;
            instr(1'b1, 1'b0, 12'h000, 2'h0);
        end
        $display("peripheral test done");
    endtask

    // Entry during an early cycle of the option-clearing write
    task automatic t_defect();
        fl <= 2'h2;
        instr(1'b0, 1'b0, 12'h000, 2'h0);
        sn[3] <= 1'b0;
        ldc <= 1'b1;
        ldn <= 4'h1;
        instr(1'b0, 1'b1, 12'hff2, 2'h1);
        ldc <= 1'b0;
        cmp("flags_out", 2'h2, flags_out);
        axi_rd(12'h0cc, 32'h0000_0009, RESP_OKAY);
        fl <= 2'h1;
        instr(1'b0, 1'b0, 12'h000, 2'h1);
        cmp("flags_out", 2'h1, flags_out);
        sn[3] <= 1'b1;
        instr(1'b1, 1'b0, 12'h000, 2'h0);
        $display("defect test done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_enable();
        t_prio();
        t_edge();
        t_periph();
        t_defect();
        summarize();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        summarize();
    end
endmodule

/* File: rtl/irq_ctrl_pkg.sv */
// Package for the priority interrupt controller: register map, fields, vectors, modes
package irq_ctrl_pkg;
    // AXI4-Lite byte addresses
    localparam logic [11:0] IRQ_OPTION_ADDR = 12'h0_0c8;
    localparam logic [11:0] STATUS_ADDR = 12'h0_0cc;
    localparam logic [7:0] IRQ_OPTION_RESET = 8'h00;
    // Option register field positions
    localparam int SRC1_LEVEL_BIT = 6;
    localparam int SRC2_POL_BIT = 5;
    localparam int GLOBAL_EN_BIT = 4;
    localparam logic [7:0] IRQ_OPTION_USED = 8'h70;
    // Vector addresses, low byte of each pair
    localparam logic [11:0] VEC_SRC0 = 12'hffc;
    localparam logic [11:0] VEC_SRC1 = 12'hff6;
    localparam logic [11:0] VEC_SRC2 = 12'hff4;
    localparam logic [11:0] VEC_SRC3 = 12'hff2;
    localparam logic [11:0] VEC_SRC4 = 12'hff0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Cycles of the option-clearing write exposed to the mode-flag defect
    localparam int DEFECT_CYCLES = 3;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_IRQ = 2'b01,
        MODE_NMI = 2'b10
    } cpu_mode_e;

    typedef struct packed {
        logic c;
        logic z;
    } flag_pair_s;

    // Core handshake at instruction boundaries
    typedef struct packed {
        logic instr_end;
        logic return_from_irq_instr;
        logic [11:0] pc;
        flag_pair_s flags;
        logic [3:0] ldi_cycle;
        logic ldi_clear_opt;
    } core_req_s;
endpackage

/* File: rtl/priority_interrupt_controller.sv */
// Priority interrupt controller with flag-set switching and AXI4-Lite option register
//
// Contract
// R1: Five sources: non-maskable source 0 on top, maskable sources 1 to 4.
// R2: Vectors FFCh, FF6h, FF4h, FF2h, FF0h for sources 0 through 4.
// R3: Accepted request loads program counter with that source's vector address.
// R4: Non-maskable pre-empts any routine; maskable routines never pre-empt each other.
// R5: Pending maskable requests served in fixed order, source 1 highest.
// R6: Global enable also gates wake-up for all sources, non-maskable included.
// R7: Non-maskable request held in a flip-flop, cleared when its routine begins.
// R8: Source 1 level-sensitive when bit 6 set, falling edge when clear.
// R9: Source 2 edge only; bit 5 set rising, clear falling.
// R10: Sources 3 and 4 level-sensitive low, no storage; requester holds level.
// R11: Edge latch sets on edge, clears on entry; extra edges collapse into one.
// R12: Requests sampled at instruction end; next instruction replaced by service entry.
// R13: Entry swaps flags, pushes PC, inhibits maskables, clears latch, loads vector.
// R14: Three independent carry/zero sets for normal, interrupt, non-maskable modes.
// R15: Return restores previous flag set and pops saved program counter.
// R16: Option register at 0C8h is write-only, whole-word, resets to 00h; code writes it on any write with the low byte strobe set.
// R17: Bit 4 global enable; clear disables all but the non-maskable source.
// R18: Option bits 7 and 3 to 0 have no function.
// R19: Maskable entry during early cycles of option-clearing write keeps normal flags.
// R20: Peripheral events ORed onto their sources.
// R21: Option writes take effect by the sampling at the writing instruction's end; code does so for bit 4 only, bits 6 and 5 a cycle later.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module priority_interrupt_controller (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic nmi_n,
    input wire logic supply_supervisor,
    input wire logic src1_n,
    input wire logic spi_done,
    input wire logic src2_n,
    input wire logic port_event,
    input wire logic src3_n,
    input wire logic timer_ovf,
    input wire logic osc32k_event,
    input wire logic src4_n,
    input wire logic adc_done,
    input wire irq_ctrl_pkg::core_req_s core_req,
    output logic take_irq,
    output logic [11:0] pc_load,
    output logic [11:0] stack_push,
    output logic [11:0] pc_pop,
    output logic pop_valid,
    output irq_ctrl_pkg::flag_pair_s flags_out,
    output irq_ctrl_pkg::cpu_mode_e mode_out,
    output logic wake
);
    import irq_ctrl_pkg::*;

    // Bus slave state
    logic aw_hold_reg, aw_hold_next;
    logic w_hold_reg, w_hold_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [7:0] opt_reg, opt_next;
    logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;

    // Interrupt state
    logic nmi_prev_reg, nmi_prev_next;
    logic src1_prev_reg, src1_prev_next;
    logic src2_prev_reg, src2_prev_next;
    logic nmi_latch_reg, nmi_latch_next;
    logic src1_latch_reg, src1_latch_next;
    logic src2_latch_reg, src2_latch_next;
    cpu_mode_e mode_reg, mode_next;
    cpu_mode_e prev_mode_reg, prev_mode_next;
    flag_pair_s flag_n_reg, flag_n_next;
    flag_pair_s flag_i_reg, flag_i_next;
    flag_pair_s flag_m_reg, flag_m_next;
    logic take_reg, take_next;
    logic [11:0] pc_load_reg, pc_load_next;
    logic [11:0] push_reg, push_next;
    logic [11:0] pop_reg, pop_next;
    logic pop_valid_reg, pop_valid_next;
    logic wake_reg, wake_next;
    logic [11:0] saved_pc_n_reg, saved_pc_n_next;
    logic [11:0] saved_pc_i_reg, saved_pc_i_next;
    logic flag_stuck_reg, flag_stuck_next;

    logic global_irq_enable, wr_fire, wr_ok, nmi_line, s1_line, s2_line, s3_line, s4_line;
    logic s1_edge, s2_edge, nmi_edge, s1_req, s2_req, mask_req, defect_hit;
    logic [7:0] opt_word;

    always_comb begin
        // Enable bit of the opt word is effective the same cycle it is written
        wr_fire = (aw_hold_reg || s_axi_awvalid) && (w_hold_reg || s_axi_wvalid) && !bvalid_reg;
        wr_ok = wr_fire && (aw_hold_reg ? awaddr_reg : s_axi_awaddr) == IRQ_OPTION_ADDR;
        opt_word = w_hold_reg ? wdata_reg[7:0] : s_axi_wdata[7:0];
    end

    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        opt_next = opt_reg;
        if (s_axi_awvalid && !aw_hold_reg && !bvalid_reg) begin
            awaddr_next = s_axi_awaddr;
            aw_hold_next = 1'b1;
        end
        if (s_axi_wvalid && !w_hold_reg && !bvalid_reg) begin
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
            w_hold_next = 1'b1;
        end
        if (wr_fire) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
            // Whole-byte writes only, unused bits dropped
            if (wr_ok && (w_hold_reg ? wstrb_reg[0] : s_axi_wstrb[0])) begin
                opt_next = opt_word[7:0] & IRQ_OPTION_USED; // R16 R18
            end
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next = 32'h0000_0000;
            rresp_next = RESP_SLVERR;
            if (s_axi_araddr == STATUS_ADDR) begin
                rresp_next = RESP_OKAY;
                rdata_next = {24'h00_0000, 1'b0, src2_latch_reg, src1_latch_reg,
                    nmi_latch_reg, flag_stuck_reg, 1'b0, mode_reg};
            end
            // Option register is write-only: read answers error
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        // Ready flops follow next state, so they match a decode of the state flops
        awready_next = !aw_hold_next && !bvalid_next;
        wready_next = !w_hold_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
            opt_reg <= IRQ_OPTION_RESET; // R16
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            arready_reg <= 1'b1;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            opt_reg <= opt_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
        end
    end

    always_comb begin
        // Active-low lines; peripheral events pull them active
        nmi_line = !nmi_n || supply_supervisor; // R20
        s1_line = !src1_n || spi_done; // R20
        s2_line = !src2_n || port_event; // R20
        s3_line = !src3_n || timer_ovf || osc32k_event; // R20 R10
        s4_line = !src4_n || adc_done; // R20 R10
        // R21: a write in flight this cycle already steers sampling
        global_irq_enable = wr_ok ? opt_word[GLOBAL_EN_BIT] : opt_reg[GLOBAL_EN_BIT]; // R17 R21
        nmi_edge = nmi_line && !nmi_prev_reg;
        s1_edge = s1_line && !src1_prev_reg; // R8
        // R9: set polarity bit means rising pin, i.e. falling active level
        s2_edge = opt_reg[SRC2_POL_BIT] ? (!s2_line && src2_prev_reg)
                                        : (s2_line && !src2_prev_reg); // R9
        s1_req = opt_reg[SRC1_LEVEL_BIT] ? s1_line : src1_latch_reg; // R8
        s2_req = src2_latch_reg;
        mask_req = global_irq_enable && (mode_reg == MODE_NORMAL)
            && (s1_req || s2_req || s3_line || s4_line);
        // R19: the clearing write's early cycles expose the defect
        defect_hit = core_req.ldi_clear_opt && core_req.ldi_cycle < 4'(DEFECT_CYCLES);
    end

    always_comb begin
        nmi_prev_next = nmi_line;
        src1_prev_next = s1_line;
        src2_prev_next = s2_line;
        nmi_latch_next = nmi_latch_reg || nmi_edge; // R7
        src1_latch_next = src1_latch_reg || (s1_edge && !opt_reg[SRC1_LEVEL_BIT]); // R11
        src2_latch_next = src2_latch_reg || s2_edge; // R11
        mode_next = mode_reg;
        prev_mode_next = prev_mode_reg;
        flag_n_next = flag_n_reg;
        flag_i_next = flag_i_reg;
        flag_m_next = flag_m_reg;
        saved_pc_n_next = saved_pc_n_reg;
        saved_pc_i_next = saved_pc_i_reg;
        flag_stuck_next = flag_stuck_reg;
        take_next = 1'b0;
        pop_valid_next = 1'b0;
        pc_load_next = pc_load_reg;
        push_next = push_reg;
        pop_next = pop_reg;
        wake_next = global_irq_enable
            && (nmi_latch_reg || s1_req || s2_req || s3_line || s4_line); // R6
        // R14: core writes flags of the active set
        if (core_req.instr_end) begin
            case (mode_reg)
                MODE_NORMAL: flag_n_next = core_req.flags;
                MODE_IRQ: begin
                    // Defect leaves the core working on the normal pair
                    if (flag_stuck_reg) begin
                        flag_n_next = core_req.flags; // R19
                    end else begin
                        flag_i_next = core_req.flags;
                    end
                end
                MODE_NMI: flag_m_next = core_req.flags;
                default: flag_n_next = core_req.flags;
            endcase
        end
        if (core_req.instr_end && core_req.return_from_irq_instr && mode_reg != MODE_NORMAL) begin
            mode_next = (mode_reg == MODE_NMI) ? prev_mode_reg : MODE_NORMAL; // R15
            pop_next = (mode_reg == MODE_NMI) ? saved_pc_i_reg : saved_pc_n_reg; // R15
            pop_valid_next = 1'b1;
            flag_stuck_next = 1'b0;
        end else if (core_req.instr_end && nmi_latch_reg && mode_reg != MODE_NMI) begin // R12 R1
            prev_mode_next = mode_reg; // R4
            mode_next = MODE_NMI; // R13 R14
            saved_pc_i_next = core_req.pc; // R13
            push_next = core_req.pc; // R13
            // A new edge this cycle is not lost to the clear
            nmi_latch_next = nmi_edge; // R7 R13
            pc_load_next = VEC_SRC0; // R2 R3
            take_next = 1'b1;
        end else if (core_req.instr_end && mask_req) begin // R12 R4
            mode_next = MODE_IRQ; // R13
            flag_stuck_next = defect_hit; // R19
            saved_pc_n_next = core_req.pc; // R13
            push_next = core_req.pc; // R13
            take_next = 1'b1;
            if (s1_req) begin // R5
                pc_load_next = VEC_SRC1; // R2 R3
                src1_latch_next = s1_edge && !opt_reg[SRC1_LEVEL_BIT]; // R11 R13
            end else if (s2_req) begin
                pc_load_next = VEC_SRC2; // R2 R3
                src2_latch_next = s2_edge; // R11 R13
            end else if (s3_line) begin
                pc_load_next = VEC_SRC3; // R2 R3
            end else begin
                pc_load_next = VEC_SRC4; // R2 R3
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_prev_reg <= 1'b0;
            src1_prev_reg <= 1'b0;
            src2_prev_reg <= 1'b0;
            nmi_latch_reg <= 1'b0;
            src1_latch_reg <= 1'b0;
            src2_latch_reg <= 1'b0;
            mode_reg <= MODE_NORMAL;
            prev_mode_reg <= MODE_NORMAL;
            flag_n_reg <= '0;
            flag_i_reg <= '0;
            flag_m_reg <= '0;
            take_reg <= 1'b0;
            pc_load_reg <= 12'h000;
            push_reg <= 12'h000;
            pop_reg <= 12'h000;
            pop_valid_reg <= 1'b0;
            wake_reg <= 1'b0;
            saved_pc_n_reg <= 12'h000;
            saved_pc_i_reg <= 12'h000;
            flag_stuck_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_prev_next;
            src1_prev_reg <= src1_prev_next;
            src2_prev_reg <= src2_prev_next;
            nmi_latch_reg <= nmi_latch_next;
            src1_latch_reg <= src1_latch_next;
            src2_latch_reg <= src2_latch_next;
            mode_reg <= mode_next;
            prev_mode_reg <= prev_mode_next;
            flag_n_reg <= flag_n_next;
            flag_i_reg <= flag_i_next;
            flag_m_reg <= flag_m_next;
            take_reg <= take_next;
            pc_load_reg <= pc_load_next;
            push_reg <= push_next;
            pop_reg <= pop_next;
            pop_valid_reg <= pop_valid_next;
            wake_reg <= wake_next;
            saved_pc_n_reg <= saved_pc_n_next;
            saved_pc_i_reg <= saved_pc_i_next;
            flag_stuck_reg <= flag_stuck_next;
        end
    end

    // Flag set shown follows mode; the defect keeps the normal pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_out <= '0;
        end else begin
            case (mode_next)
                MODE_IRQ: flags_out <= flag_stuck_next ? flag_n_next : flag_i_next; // R14 R19
                MODE_NMI: flags_out <= flag_m_next; // R14
                default: flags_out <= flag_n_next;
            endcase
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign take_irq = take_reg;
    assign pc_load = pc_load_reg;
    assign stack_push = push_reg;
    assign pc_pop = pop_reg;
    assign pop_valid = pop_valid_reg;
    assign mode_out = mode_reg;
    assign wake = wake_reg;

    nmi_vector_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take_irq && mode_out == MODE_NMI |-> pc_load == VEC_SRC0) // R2
        else $error("nmi entry without nmi vector");
    no_nest_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_reg == MODE_IRQ && !core_req.return_from_irq_instr |=> mode_reg != MODE_NORMAL) // R4
        else $error("maskable routine left without return");
    prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
        core_req.instr_end && mask_req && s1_req && !(nmi_latch_reg)
        && !core_req.return_from_irq_instr
        |=> pc_load == VEC_SRC1) // R5
        else $error("source 1 not served first");
    enable_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !global_irq_enable |=> !(take_irq && mode_out == MODE_IRQ)) // R17
        else $error("maskable taken with enable clear");
    nmi_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        nmi_latch_reg && !take_next |=> nmi_latch_reg) // R7
        else $error("nmi latch lost");
    wake_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !global_irq_enable |=> !wake) // R6
        else $error("wake with enable clear");
    src2_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s2_edge |=> src2_latch_reg) // R9
        else $error("source 2 edge not latched");
    unused_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (opt_reg & ~IRQ_OPTION_USED) == 8'h00) // R18
        else $error("unused option bits set");
    return_from_irq_instr_pop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        core_req.instr_end && core_req.return_from_irq_instr && mode_reg == MODE_IRQ
        |=> pop_valid && mode_reg == MODE_NORMAL) // R15
        else $error("return did not pop");
endmodule
